// File: core/gsp_buf.sv
// Small byte buffer holding burst data, with registered read data.
`timescale 1ns/1ps
module gsp_buf #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Write port.
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [WIDTH-1:0] i_wdata,
   // Read port.
   input wire logic [AW-1:0] i_raddr,
   output logic [WIDTH-1:0] o_rdata
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0] rdata;
   } gsp_buf_regs_t;

   gsp_buf_regs_t r_reg;
   gsp_buf_regs_t r_next;

   always_comb begin
      r_next = r_reg;
      r_next.rdata = r_reg.mem[i_raddr];
      if (i_we) begin
         r_next.mem[i_waddr] = i_wdata;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_rdata = r_reg.rdata;
endmodule : gsp_buf

// File: core/gsp_host.sv
// SPI host controller for the gyro register port, commanded over APB.
//
// Overview of operation
// - Serial clock never runs faster than 10 MHz, in both wiring modes.
// - Software should set the sensor's I2C-block bit when the bus is shared.
// - Frame is 16 clocks for one byte, plus 8 per extra byte.
// - Bits start on falling clock edges; chip select rises after last bit.
// - First frame bit is direction: 0 writes, 1 reads.
// - Frame bits 2 to 7 carry the six-bit register index.
// - Frame bits 8 to 15 carry the data byte, MSB first.
// - Serial clock is at its idle level before chip select falls.
// - Bursts keep chip select low in 8-clock groups; raising it ends them.
// - In three-wire mode the data pin is shared and turned around.
// - In both wiring modes the first bit goes onto the pin as chip select falls.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module gsp_host
   import gsp_pkg::*;
#(
   parameter int HALF_CYC_P = gsp_pkg::HALF_CYC
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_b,
   // APB slave.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [gsp_pkg::APB_AW-1:0] i_paddr,
   input wire logic [gsp_pkg::APB_DW-1:0] i_pwdata,
   output logic [gsp_pkg::APB_DW-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Serial link to the sensor.
   output logic o_sclk,
   output logic o_cs_b,
   output logic o_sdi_o,
   output logic o_sdi_oe,
   input wire logic i_sdi_i,
   input wire logic i_sdo
);
   import gsp_pkg::*;

   localparam logic [3:0] HALF_LAST = 4'(HALF_CYC_P - 1);

   typedef struct packed {
      gsp_state_t st;
      logic [3:0] div;
      logic [2:0] bit_cnt;
      logic [4:0] byte_cnt;
      logic three_wire;
      logic hold;
      logic rw;
      logic [IDX_W-1:0] idx;
      logic [LEN_W-1:0] len;
      logic [BYTE_BITS-1:0] sh_tx;
      logic [BYTE_BITS-1:0] sh_rx;
      logic sclk;
      logic cs_b;
      logic sdi_o;
      logic sdi_oe;
      logic done;
      logic pready;
      logic pslverr;
      logic [APB_DW-1:0] prdata;
   } gsp_host_regs_t;

   gsp_host_regs_t r_reg;
   gsp_host_regs_t r_next;

   logic [1:0] pins_sync;
   logic din;
   logic busy;
   logic half_end;
   logic last_bit;
   logic done_set;
   logic done_clr;
   logic apb_wr;
   logic apb_acc;
   logic is_ctrl;
   logic is_stat;
   logic is_buf;
   logic mem_we;
   logic [BUF_AW-1:0] mem_waddr;
   logic [BYTE_BITS-1:0] mem_wdata;
   logic [BUF_AW-1:0] mem_raddr;
   logic [BYTE_BITS-1:0] mem_rdata;
   logic [APB_DW-1:0] rd;
   logic [BYTE_BITS-1:0] rx_byte;
   logic [4:0] last_byte;

   gsp_sync #(
      .WIDTH(2)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_async({i_sdi_i, i_sdo}),
      .o_sync(pins_sync)
   );

   gsp_buf #(
      .WIDTH(BYTE_BITS),
      .DEPTH(BUF_DEPTH),
      .AW(BUF_AW)
   ) u_buf (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_we(mem_we),
      .i_waddr(mem_waddr),
      .i_wdata(mem_wdata),
      .i_raddr(mem_raddr),
      .o_rdata(mem_rdata)
   );

   always_comb begin
      r_next = r_reg;
      busy = (r_reg.st != GSP_IDLE);
      // In three-wire mode read data come back on the shared data pin.
      din = r_reg.three_wire ? pins_sync[1] : pins_sync[0];
      half_end = (r_reg.div == HALF_LAST);
      last_byte = 5'({1'b0, r_reg.len} + 5'd1);
      last_bit = (r_reg.bit_cnt == 3'd7) && (r_reg.byte_cnt == last_byte);
      rx_byte = {r_reg.sh_rx[BYTE_BITS-2:0], din};
      done_set = 1'b0;
      done_clr = 1'b0;
      mem_we = 1'b0;
      mem_waddr = '0;
      mem_wdata = '0;
      mem_raddr = r_reg.byte_cnt[BUF_AW-1:0];
      rd = '0;
      r_next.div = half_end ? 4'd0 : 4'(r_reg.div + 4'd1);

      // Address decode.
      is_ctrl = 1'b0;
      is_stat = 1'b0;
      is_buf = 1'b0;
      if (i_paddr == ADDR_CTRL) begin
         is_ctrl = 1'b1;
      end else if (i_paddr == ADDR_STAT) begin
         is_stat = 1'b1;
      end else if ((i_paddr & ~BUF_MASK) == ADDR_BUF) begin
         is_buf = 1'b1;
      end
      apb_acc = i_psel & i_penable & ~r_reg.pready;
      apb_wr = i_psel & i_penable & r_reg.pready & i_pwrite & ~r_reg.pslverr;

      case (r_reg.st)
         GSP_IDLE: begin
            r_next.div = '0;
            r_next.sclk = 1'b1;
            r_next.cs_b = 1'b1;
            // Buffer belongs to APB while the link is idle.
            mem_raddr = i_paddr[BUF_AW+1:2];
            if (apb_wr && is_buf) begin
               mem_we = 1'b1;
               mem_waddr = i_paddr[BUF_AW+1:2];
               mem_wdata = i_pwdata[BYTE_BITS-1:0];
            end
         end
         GSP_LEAD: begin
            if (half_end) begin
               r_next.st = GSP_LOW;
               r_next.sclk = 1'b0;
            end
         end
         GSP_LOW: begin
            if (half_end) begin
               r_next.st = GSP_HIGH;
               r_next.sclk = 1'b1;
               r_next.sh_rx = rx_byte;
               if (r_reg.rw == RW_READ && r_reg.byte_cnt != 5'd0 && r_reg.bit_cnt == 3'd7) begin
                  // Read data are valid from frame bit 8 on, and each byte lands here.
                  mem_we = 1'b1;
                  mem_waddr = BUF_AW'(r_reg.byte_cnt - 5'd1);
                  mem_wdata = rx_byte;
               end
            end
         end
         GSP_HIGH: begin
            if (half_end) begin
               if (last_bit) begin
                  // Chip select rises half a period after the last rising edge.
                  r_next.st = GSP_TAIL;
                  r_next.cs_b = 1'b1;
               end else begin
                  r_next.st = GSP_LOW;
                  r_next.sclk = 1'b0;
                  if (r_reg.bit_cnt == 3'd7) begin
                     // Next byte group of 8 clocks, chip select held low.
                     r_next.bit_cnt = 3'd0;
                     r_next.byte_cnt = 5'(r_reg.byte_cnt + 5'd1);
                     r_next.sh_tx = (r_reg.rw == RW_READ) ? '0 : mem_rdata;
                     if (r_reg.three_wire && r_reg.rw == RW_READ) begin
                        r_next.sdi_oe = 1'b0;
                     end
                  end else begin
                     r_next.bit_cnt = 3'(r_reg.bit_cnt + 3'd1);
                     r_next.sh_tx = {r_reg.sh_tx[BYTE_BITS-2:0], 1'b0};
                  end
               end
            end
         end
         GSP_TAIL: begin
            r_next.cs_b = 1'b1;
            if (half_end) begin
               r_next.st = GSP_IDLE;
               r_next.sdi_oe = 1'b1;
               done_set = 1'b1;
            end
         end
         default: begin
            r_next.st = GSP_IDLE;
         end
      endcase
      r_next.sdi_o = r_next.sh_tx[BYTE_BITS-1];

      // Register writes take effect on the edge where pready is seen high.
      if (apb_wr && is_ctrl && i_pwdata[CTRL_START_BIT]) begin
         r_next.three_wire = i_pwdata[CTRL_3W_BIT];
         r_next.hold = i_pwdata[CTRL_HOLD_BIT];
         r_next.rw = i_pwdata[CTRL_RW_BIT];
         r_next.idx = i_pwdata[CTRL_IDX_LSB +: IDX_W];
         r_next.len = i_pwdata[CTRL_LEN_LSB +: LEN_W];
         r_next.st = GSP_LEAD;
         r_next.div = '0;
         r_next.bit_cnt = '0;
         r_next.byte_cnt = '0;
         r_next.sh_rx = '0;
         // Clock is already idle high here, before chip select falls.
         r_next.sclk = 1'b1;
         r_next.cs_b = 1'b0;
         // Command byte: direction, address hold, index, with bit 7 presented first.
         r_next.sh_tx = {i_pwdata[CTRL_RW_BIT], i_pwdata[CTRL_HOLD_BIT], i_pwdata[CTRL_IDX_LSB +: IDX_W]};
         r_next.sdi_o = i_pwdata[CTRL_RW_BIT];
         r_next.sdi_oe = 1'b1;
      end else if (apb_wr && is_ctrl) begin
         r_next.three_wire = i_pwdata[CTRL_3W_BIT];
         r_next.hold = i_pwdata[CTRL_HOLD_BIT];
         r_next.rw = i_pwdata[CTRL_RW_BIT];
         r_next.idx = i_pwdata[CTRL_IDX_LSB +: IDX_W];
         r_next.len = i_pwdata[CTRL_LEN_LSB +: LEN_W];
      end
      if (apb_wr && is_stat && i_pwdata[STAT_DONE_BIT]) begin
         done_clr = 1'b1;
      end
      // A completion in the same cycle as its clear is kept.
      r_next.done = done_set | (r_reg.done & ~done_clr);

      // Read data and error are captured in the first access cycle.
      if (is_ctrl) begin
         rd[CTRL_3W_BIT] = r_reg.three_wire;
         rd[CTRL_HOLD_BIT] = r_reg.hold;
         rd[CTRL_RW_BIT] = r_reg.rw;
         rd[CTRL_IDX_LSB +: IDX_W] = r_reg.idx;
         rd[CTRL_LEN_LSB +: LEN_W] = r_reg.len;
      end else if (is_stat) begin
         rd[STAT_BUSY_BIT] = busy;
         rd[STAT_DONE_BIT] = r_reg.done;
      end else if (is_buf) begin
         rd[BYTE_BITS-1:0] = mem_rdata;
      end
      r_next.pready = apb_acc;
      if (apb_acc) begin
         r_next.pslverr = ~(is_ctrl | is_stat | is_buf) | (busy & (is_buf | (is_ctrl & i_pwrite)));
         r_next.prdata = i_pwrite ? '0 : rd;
      end else begin
         r_next.pslverr = 1'b0;
         r_next.prdata = '0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         r_reg <= '0;
         r_reg.st <= GSP_IDLE;
         r_reg.sclk <= 1'b1;
         r_reg.cs_b <= 1'b1;
         r_reg.sdi_oe <= 1'b1;
         r_reg.three_wire <= 1'b0;
         r_reg.prdata <= RST_PRDATA;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_prdata = r_reg.prdata;
   assign o_pready = r_reg.pready;
   assign o_pslverr = r_reg.pslverr;
   assign o_sclk = r_reg.sclk;
   assign o_cs_b = r_reg.cs_b;
   assign o_sdi_o = r_reg.sdi_o;
   assign o_sdi_oe = r_reg.sdi_oe;
endmodule : gsp_host

// File: core/gsp_sync.sv
// Two-flop synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ps
module gsp_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Asynchronous levels in, synchronised levels out.
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } gsp_sync_regs_t;

   gsp_sync_regs_t r_reg;
   gsp_sync_regs_t r_next;

   always_comb begin
      r_next.meta = i_async;
      r_next.sync = r_reg.meta;
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_sync = r_reg.sync;
endmodule : gsp_sync

// File: dv/gsp_host_sva.sv
// Assertions on the ports of the gyro SPI host controller.
`timescale 1ns/1ps
module gsp_host_sva #(
   parameter int HALF_CYC_P = 5
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_sclk,
   input wire logic o_cs_b,
   input wire logic o_sdi_o,
   input wire logic o_sdi_oe,
   input wire logic i_sdi_i,
   input wire logic i_sdo
);
   int low_cnt;
   int rise_cnt;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         low_cnt <= 0;
         rise_cnt <= 0;
      end else begin
         low_cnt <= o_sclk ? 0 : low_cnt + 1;
         rise_cnt <= o_cs_b ? 0 : rise_cnt + int'($rose(o_sclk));
      end
   end
   a_half_period: assert property ($rose(o_sclk) |-> low_cnt == HALF_CYC_P)
      else $error("serial clock low phase has the wrong length");
   a_frame_len: assert property ($rose(o_cs_b) |-> rise_cnt >= 16 && rise_cnt % 8 == 0)
      else $error("frame clock count is not 16 plus whole bytes");
   a_idle_clock: assert property (o_cs_b |-> o_sclk)
      else $error("serial clock not idle while deselected");
   a_select_drive: assert property ($fell(o_cs_b) |-> o_sdi_oe && $past(o_sdi_oe))
      else $error("data pin not driven when selecting");
   a_bit_stable: assert property (!o_cs_b && $past(!o_cs_b) && o_sclk && $past(o_sclk) |-> $stable(o_sdi_o))
      else $error("data changed outside a falling clock edge");
   a_last_edge: assert property ($rose(o_cs_b) |-> o_sclk && $past(o_sclk))
      else $error("chip select rose with the clock low");
   a_release_bit8: assert property ($fell(o_sdi_oe) |-> !o_cs_b && rise_cnt == 8)
      else $error("data pin released at the wrong bit");
   a_pready_wait: assert property (i_psel && i_penable && !$past(i_penable) |=> o_pready)
      else $error("bus answer not after one wait state");
   a_pready_pulse: assert property (o_pready |=> !o_pready)
      else $error("bus answer longer than one cycle");
   a_idle_data: assert property (!o_pready |-> o_prdata == 32'h0 && !o_pslverr)
      else $error("bus outputs not quiet between answers");
endmodule : gsp_host_sva
bind gsp_host gsp_host_sva #(.HALF_CYC_P(HALF_CYC_P)) gsp_host_sva_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_sclk(o_sclk), .o_cs_b(o_cs_b),
   .o_sdi_o(o_sdi_o), .o_sdi_oe(o_sdi_oe), .i_sdi_i(i_sdi_i), .i_sdo(i_sdo));

// File: dv/gsp_sensor_model.sv
// Behavioural model of the gyro sensor's SPI register port.
`timescale 1ns/1ps
module gsp_sensor_model #(
   // Index of the interface configuration register; the value is arbitrary.
   parameter logic [5:0] IFCFG_IDX = 6'h3f
) (
   input wire logic i_sclk,
   input wire logic i_cs_b,
   input wire logic i_din,
   output logic o_sdo,
   output logic o_dio,
   output logic o_dio_oe
);
   localparam logic [7:0] PAT = 8'h96;
   logic [7:0] mem [64];
   logic [7:0] sh;
   logic [5:0] idx;
   logic rw, hold, three, bitv;
   int cnt, nclk;
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      three = 1'h0;
      o_sdo = 1'h0;
      o_dio = 1'h0;
      o_dio_oe = 1'h0;
      cnt = 0;
   end
   always @(negedge i_cs_b) cnt = 0;
   // A released output shows the inverse of its last level.
   always @(posedge i_cs_b) begin
      o_dio_oe = 1'h0;
      o_sdo = ~o_sdo;
      nclk = cnt;
   end
   always @(posedge i_sclk) begin
      if (!i_cs_b) begin
         sh = {sh[6:0], i_din};
         cnt++;
         if (cnt == 8) begin
            rw = sh[7];
            hold = sh[6];
            idx = sh[5:0];
         end else if (cnt >= 16 && cnt % 8 == 0) begin
            if (!rw) mem[idx] = sh;
            if (!rw && idx == IFCFG_IDX) three = sh[0];
            if (!hold) idx++;
         end
      end
   end
   always @(negedge i_sclk) begin
      if (!i_cs_b) begin
         bitv = (cnt < 8) ? PAT[7 - cnt] : (rw ? mem[idx][7 - cnt % 8] : 1'h0);
         o_sdo = three ? ~o_sdo : bitv;
         if (three && rw && cnt >= 8) o_dio = bitv;
         if (three && rw && cnt >= 8) o_dio_oe = 1'h1;
      end
   end
endmodule : gsp_sensor_model

// File: dv/test_gsp_host.sv
// Self-checking bench of the gyro SPI host controller with a sensor model.
`timescale 1ns/1ps
module test_gsp_host;
   import gsp_pkg::*;
   localparam logic [5:0] CFG = 6'h3f;
   // Sensor register that blocks the other bus mode, and the value written to it.
   localparam logic [5:0] I2C_OFF_IDX = 6'h15;
   localparam logic [7:0] I2C_OFF_VAL = 8'h01;
   logic i_clk, i_rst_b, psel, pen, pwr, pin_last, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic pready, pslverr, sclk, cs_b, sdi_o, sdi_oe, sdo, dio, dio_oe;
   // Shared data pin: a released pin toggles rather than holding its level.
   wire pin = sdi_oe ? sdi_o : (dio_oe ? dio : ~pin_last);
   int failures, num_checks;
   gsp_host gsp_host_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .o_sclk(sclk), .o_cs_b(cs_b), .o_sdi_o(sdi_o), .o_sdi_oe(sdi_oe),
      .i_sdi_i(pin), .i_sdo(sdo));
   gsp_sensor_model #(.IFCFG_IDX(CFG)) gsp_sensor_model_inst (.i_sclk(sclk), .i_cs_b(cs_b),
      .i_din(pin), .o_sdo(sdo), .o_dio(dio), .o_dio_oe(dio_oe));
   initial begin
      i_clk = 1'h0;
      forever #5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) pin_last <= pin;
   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      pen <= 1'h1;
      do begin
         @(posedge i_clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      pen <= 1'h0;
      if (pready !== 1'h1) begin
         failures++;
         end_of_test();
      end
   endtask : apb
   task start(input logic rw, input logic hold, input logic three, input logic [5:0] idx, input logic [3:0] len);
      apb(1'h1, ADDR_CTRL, {12'h000, len, 2'h0, idx, 4'h0, rw, hold, three, 1'h1});
   endtask : start
   task wait_done;
      int n;
      n = 0;
      do begin
         apb(1'h0, ADDR_STAT, 32'h0);
         n++;
      end while (r[1] !== 1'h1 && n < 300);
      if (r[1] !== 1'h1) begin
         failures++;
         end_of_test();
      end else begin
         apb(1'h1, ADDR_STAT, 32'h2);
         apb(1'h0, ADDR_STAT, 32'h0);
         chk(r, 32'h0);
      end
   endtask : wait_done
   task bw(input int i, input logic [7:0] v);
      apb(1'h1, ADDR_BUF + 12'(4 * i), {24'h0, v});
   endtask : bw
   task bchk(input int i, input logic [7:0] v);
      apb(1'h0, ADDR_BUF + 12'(4 * i), 32'h0);
      chk(r, {24'h0, v});
   endtask : bchk
   task mchk(input int i, input logic [7:0] v);
      chk(32'(gsp_sensor_model_inst.mem[i]), {24'h0, v});
   endtask : mchk
   task t_reset;
      chk(32'({cs_b, sclk, sdi_oe}), 32'h7);
      apb(1'h0, ADDR_CTRL, 32'h0);
      chk(r, 32'h0);
      apb(1'h0, 12'h100, 32'h0);
      chk(32'(e), 32'h1);
      chk(r, 32'h0);
      $display("reset and unmapped test done");
   endtask : t_reset
   task t_config;
      apb(1'h1, ADDR_CTRL, 32'h0003_150c);
      apb(1'h0, ADDR_CTRL, 32'h0);
      chk(r, 32'h0003_150c);
      apb(1'h0, ADDR_STAT, 32'h0);
      chk(r, 32'h0);
      bw(0, I2C_OFF_VAL);
      start(1'h0, 1'h0, 1'h0, I2C_OFF_IDX, 4'h0);
      wait_done();
      mchk(int'(I2C_OFF_IDX), I2C_OFF_VAL);
      $display("config test done");
   endtask : t_config
   task t_write;
      bw(0, 8'h5a);
      bw(1, 8'hc3);
      bw(2, 8'h81);
      start(1'h0, 1'h0, 1'h0, 6'h05, 4'h2);
      wait_done();
      mchk(5, 8'h5a);
      mchk(7, 8'h81);
      chk(32'(gsp_sensor_model_inst.nclk), 32'd32);
      start(1'h0, 1'h1, 1'h0, 6'h20, 4'h1);
      wait_done();
      mchk(32, 8'hc3);
      mchk(33, 8'h00);
      $display("write test done");
   endtask : t_write
   task t_read;
      start(1'h1, 1'h0, 1'h0, 6'h05, 4'h2);
      wait_done();
      bchk(0, 8'h5a);
      bchk(2, 8'h81);
      start(1'h1, 1'h1, 1'h0, 6'h06, 4'h1);
      wait_done();
      bchk(1, 8'hc3);
      $display("read test done");
   endtask : t_read
   task t_busy;
      bw(0, 8'h3c);
      start(1'h0, 1'h0, 1'h0, 6'h09, 4'h0);
      apb(1'h0, ADDR_STAT, 32'h0);
      chk(r, 32'h1);
      start(1'h0, 1'h0, 1'h0, 6'h0a, 4'h0);
      chk(32'(e), 32'h1);
      apb(1'h0, ADDR_BUF, 32'h0);
      chk(32'(e), 32'h1);
      wait_done();
      mchk(9, 8'h3c);
      mchk(10, 8'h00);
      $display("busy test done");
   endtask : t_busy
   task t_three;
      bw(0, 8'h01);
      start(1'h0, 1'h0, 1'h0, CFG, 4'h0);
      wait_done();
      start(1'h1, 1'h0, 1'h1, 6'h05, 4'h2);
      wait_done();
      bchk(1, 8'hc3);
      bchk(2, 8'h81);
      bw(0, 8'h00);
      start(1'h0, 1'h0, 1'h1, CFG, 4'h0);
      wait_done();
      mchk(CFG, 8'h00);
      start(1'h1, 1'h0, 1'h0, 6'h07, 4'h0);
      wait_done();
      bchk(0, 8'h81);
      $display("three-wire test done");
   endtask : t_three
   initial begin
      failures = 0;
      num_checks = 0;
      i_rst_b = 1'h0;
      psel = 1'h0;
      pen = 1'h0;
      pwr = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pin_last = 1'h0;
      repeat (3) @(posedge i_clk);
      i_rst_b <= 1'h1;
      t_reset();
      t_config();
      t_write();
      t_read();
      t_busy();
      t_three();
      end_of_test();
   end
endmodule : test_gsp_host

// File: include/gsp_pkg.sv
// Shared constants and types for the gyro SPI host controller.
package gsp_pkg;
   // System clock and the fastest serial clock that the sensor accepts (10 MHz).
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCLK_MIN_PERIOD_NS = 100;
   // Least half period of the serial clock, rounded up to whole system cycles.
   localparam int HALF_CYC = (SCLK_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Frame layout.
   localparam int BYTE_BITS = 8;
   localparam int IDX_W = 6;
   localparam logic RW_WRITE = 1'b0;
   localparam logic RW_READ = 1'b1;

   // Burst data buffer.
   localparam int BUF_DEPTH = 16;
   localparam int BUF_AW = 4;
   localparam int LEN_W = 4;

   // APB slave.
   localparam int APB_AW = 12;
   localparam int APB_DW = 32;
   localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
   localparam logic [APB_AW-1:0] ADDR_STAT = 12'h004;
   localparam logic [APB_AW-1:0] ADDR_BUF = 12'h040;
   localparam logic [APB_AW-1:0] BUF_MASK = 12'h03c;

   // Control register fields.
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_3W_BIT = 1;
   localparam int CTRL_HOLD_BIT = 2;
   localparam int CTRL_RW_BIT = 3;
   localparam int CTRL_IDX_LSB = 8;
   localparam int CTRL_LEN_LSB = 16;

   // Status register fields.
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;

   // Reset values.
   localparam logic [APB_DW-1:0] RST_PRDATA = 32'h0000_0000;

   typedef enum logic [2:0] {
      GSP_IDLE,
      GSP_LEAD,
      GSP_LOW,
      GSP_HIGH,
      GSP_TAIL
   } gsp_state_t;
endpackage : gsp_pkg
